//--- core/alc_adaptive_logic_cell.sv
// Purpose: one adaptive logic cell with two split lookup halves and two cell registers
// Assumes: configuration and lookup masks written over ahb-lite before the cell is used
// Notes:   asynchronous cluster controls act on the outputs at once and on the state at the next edge
//
// Added by the designer: the register addresses and the AHB-Lite register port.
module alc_adaptive_logic_cell
    import alc_pkg::*;
#(
    parameter int HALVES = 2
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    // cluster-wide controls
    input  wire alc_ctl_s    cluster_ctl,
    // cell inputs
    input  wire alc_din_s    cell_in,
    input  wire logic        carry_in,
    input  wire logic        share_in,
    input  wire logic        chain_in,
    // cell outputs
    output alc_dout_s        cell_out,
    output logic             carry_out,
    output logic             share_out,
    output logic             chain_out
);

`include "alc_regs.svh"

    if (HALVES != 2) begin : g_bad_halves
        $error("alc_adaptive_logic_cell: HALVES must be 2");
    end

    alc_state_s  st_r;
    alc_state_s  st_nxt;
    alc_mode_e   mode;
    logic [3:0]  abcd;
    logic [1:0]  e_in;
    logic [1:0]  f_in;
    logic [1:0]  f_lut;
    logic [1:0]  fb;
    logic [1:0]  csel;
    logic [1:0]  esel;
    logic [1:0]  off;
    logic [1:0]  lut6;
    logic [1:0]  lut5;
    logic [1:0]  x_l;
    logic [1:0]  y_l;
    logic [1:0]  aclr;
    logic [1:0]  ena;
    logic [1:0]  q_vis;
    logic [1:0]  comb;
    logic [1:0]  pack;
    logic [1:0]  chain;
    logic [1:0]  d_in;
    logic [1:0]  sel_o_a;
    logic [1:0]  sel_o_b;
    logic [1:0]  add0;
    logic [1:0]  add1;
    logic        op0;
    logic        op1;
    logic [63:0] mask [HALVES];

    assign mode  = st_r.cfg.mode;
    assign abcd  = {cell_in.in_d, cell_in.in_c, cell_in.in_b, cell_in.in_a};
    assign e_in  = {cell_in.lower_private_input_e, cell_in.upper_private_input_e};
    assign f_in  = {cell_in.lower_private_input_f, cell_in.upper_private_input_f};
    assign fb    = {st_r.cfg.fb1, st_r.cfg.fb0};
    assign csel  = {st_r.cfg.csel1, st_r.cfg.csel0};
    assign esel  = {st_r.cfg.esel1, st_r.cfg.esel0};
    assign off   = {mode == ALC_EXTENDED, 1'b0};
    assign mask[0] = st_r.mask0;
    assign mask[1] = st_r.mask1;
    assign sel_o_a = {st_r.cfg.oa1, st_r.cfg.oa0};
    assign sel_o_b = {st_r.cfg.ob1, st_r.cfg.ob0};

    // half 0 owns the upper pair, first register and top outputs
    for (genvar h = 0; h < HALVES; h++) begin : g_half
        // own register replaces the private f input when fed back
        assign f_lut[h] = fb[h] ? q_vis[h] : f_in[h];
        // shared a..d plus the private pair of this half
        assign lut6[h]  = mask[h][{f_lut[h], e_in[h], abcd}];
        assign lut5[h]  = mask[h][{1'b0, e_in[h], abcd}];
        assign x_l[h]   = mask[h][{2'b00, abcd}];
        assign y_l[h]   = mask[h][{2'b01, f_lut[h], e_in[h], cell_in.in_b, cell_in.in_a}];
        assign aclr[h]  = csel[h] ? cluster_ctl.clear_second : cluster_ctl.clear_first;
        // first enable withdrawn while asynchronous load is in use
        assign ena[h]   = (!esel[h] && st_r.cfg.aload_used) ? 1'b1
                        : esel[h] ? cluster_ctl.cluster_clock_enable_second
                        : cluster_ctl.cluster_clock_enable_first;
        assign q_vis[h] = (aclr[h] || off[h]) ? 1'b0
                        : cluster_ctl.aload ? e_in[h] : st_r.q[h];
    end

    // two-stage adder: carry in to adder0, adder0 carry to adder1
    assign op0  = (mode == ALC_SHARED) ? share_in : y_l[0];
    assign op1  = (mode == ALC_SHARED) ? y_l[0] : y_l[1];
    assign add0 = {1'b0, x_l[0]} + {1'b0, op0} + {1'b0, carry_in};
    assign add1 = {1'b0, x_l[1]} + {1'b0, op1} + {1'b0, add0[1]};

    always_comb begin
        comb = 2'b00;
        case (mode)
            ALC_NORMAL: begin
                comb = lut6;
            end
            ALC_EXTENDED: begin
                // seven inputs: a..d, both e inputs, upper f selects
                comb[0] = cell_in.upper_private_input_f ? lut5[1] : lut5[0];
                comb[1] = 1'b0;
            end
            ALC_ARITH, ALC_SHARED: begin
                comb = {add1[0], add0[0]};
            end
            default: begin
                comb = 2'b00;
            end
        endcase
    end

    // packing sources: the free private f input of each half
    assign pack[0]  = (mode == ALC_EXTENDED) ? cell_in.lower_private_input_f
                    : cell_in.upper_private_input_f;
    // lower f packs while a six-input result on it leaves unregistered
    assign pack[1]  = cell_in.lower_private_input_f;
    assign chain[0] = chain_in;
    assign chain[1] = q_vis[0];

    always_comb begin
        for (int h = 0; h < 2; h++) begin
            case (h == 0 ? st_r.cfg.dsel0 : st_r.cfg.dsel1)
                ALC_D_LOOKUP: d_in[h] = comb[h];
                ALC_D_PACK:   d_in[h] = pack[h];
                ALC_D_CHAIN:  d_in[h] = chain[h];
                default:      d_in[h] = st_r.q[h];
            endcase
        end
    end

    always_comb begin
        logic [7:0] ra;
        ra = 8'h00;
        st_nxt = st_r;
        // cell registers, asynchronous controls first
        for (int h = 0; h < 2; h++) begin
            if (off[h]) begin
                st_nxt.q[h] = 1'b0;
            end else if (aclr[h]) begin
                st_nxt.q[h] = 1'b0;
            end else if (cluster_ctl.aload) begin
                st_nxt.q[h] = e_in[h];
            end else if (!ena[h]) begin
                st_nxt.q[h] = st_r.q[h];
            end else if (cluster_ctl.sclr) begin
                st_nxt.q[h] = 1'b0;
            end else if (cluster_ctl.sload) begin
                st_nxt.q[h] = e_in[h];
            end else begin
                st_nxt.q[h] = d_in[h];
            end
        end
        // data phase of a write; settings are meant to be static while clocked
        if (st_r.pend && st_r.pwr) begin
            if (st_r.paddr == `ALC_CFG_OFS) begin
                st_nxt.cfg = alc_cfg_s'(hwdata & `ALC_CFG_WMASK);
            end else if (st_r.paddr == `ALC_MASK0_LO_OFS) begin
                st_nxt.mask0[31:0] = hwdata;
            end else if (st_r.paddr == `ALC_MASK0_HI_OFS) begin
                st_nxt.mask0[63:32] = hwdata;
            end else if (st_r.paddr == `ALC_MASK1_LO_OFS) begin
                st_nxt.mask1[31:0] = hwdata;
            end else if (st_r.paddr == `ALC_MASK1_HI_OFS) begin
                st_nxt.mask1[63:32] = hwdata;
            end
        end
        // address phase: only whole-word transfers are taken
        st_nxt.pend  = hsel && htrans[1] && hready && (hsize == `ALC_HSIZE_WORD);
        st_nxt.pwr   = hwrite;
        st_nxt.paddr = haddr[7:0];
        ra = haddr[7:0];
        if (st_nxt.pend && !hwrite) begin
            if (ra == `ALC_CFG_OFS) begin
                st_nxt.rdata = st_nxt.cfg;
            end else if (ra == `ALC_STAT_OFS) begin
                st_nxt.rdata = 32'h0000_0000;
                st_nxt.rdata[`ALC_ST_Q0]    = st_nxt.q[0];
                st_nxt.rdata[`ALC_ST_Q1]    = st_nxt.q[1];
                st_nxt.rdata[`ALC_ST_COMB0] = comb[0];
                st_nxt.rdata[`ALC_ST_COMB1] = comb[1];
                st_nxt.rdata[`ALC_ST_COUT]  = add1[1];
                st_nxt.rdata[`ALC_ST_SOUT]  = y_l[1];
            end else if (ra == `ALC_MASK0_LO_OFS) begin
                st_nxt.rdata = st_nxt.mask0[31:0];
            end else if (ra == `ALC_MASK0_HI_OFS) begin
                st_nxt.rdata = st_nxt.mask0[63:32];
            end else if (ra == `ALC_MASK1_LO_OFS) begin
                st_nxt.rdata = st_nxt.mask1[31:0];
            end else if (ra == `ALC_MASK1_HI_OFS) begin
                st_nxt.rdata = st_nxt.mask1[63:32];
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r.cfg   <= alc_cfg_s'(`ALC_CFG_RST);
            st_r.mask0 <= `ALC_MASK_RST;
            st_r.mask1 <= `ALC_MASK_RST;
            st_r.q     <= 2'b00;
            st_r.pend  <= 1'b0;
            st_r.pwr   <= 1'b0;
            st_r.paddr <= 8'h00;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // output sets: a-output also feeds local routing
    assign cell_out.top_route_a = sel_o_a[0] ? q_vis[0] : comb[0];
    assign cell_out.top_route_b = sel_o_b[0] ? q_vis[0] : comb[0];
    assign cell_out.top_local   = cell_out.top_route_a;
    assign cell_out.bot_route_a = sel_o_a[1] ? q_vis[1] : comb[1];
    assign cell_out.bot_route_b = sel_o_b[1] ? q_vis[1] : comb[1];
    assign cell_out.bot_local   = cell_out.bot_route_a;
    assign carry_out = add1[1];
    assign share_out = y_l[1];
    assign chain_out = q_vis[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdata;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_quiet0;
        !aclr[0] && !cluster_ctl.aload && !cluster_ctl.sclr && !cluster_ctl.sload;
    endsequence

    sequence s_capture0;
        s_quiet0 ##0 ena[0] && mode == ALC_NORMAL && st_r.cfg.dsel0 == ALC_D_LOOKUP;
    endsequence

    sequence s_read_cfg;
        hsel && htrans[1] && hready && !hwrite && hsize == `ALC_HSIZE_WORD && haddr[7:0] == `ALC_CFG_OFS;
    endsequence

    a_aclr_clears_q: assert property (aclr[0] && !off[0] |=> !st_r.q[0])
        else $error("first register not cleared by async clear");

    a_aload_takes_e: assert property (!aclr[0] && cluster_ctl.aload |=> st_r.q[0] == $past(e_in[0]))
        else $error("first register did not load upper e");

    a_ena_low_holds: assert property (s_quiet0 ##0 !ena[0] |=> $stable(st_r.q[0]))
        else $error("register changed with its clock stopped");

    a_bypass_top_out: assert property (!st_r.cfg.oa0 |-> cell_out.top_route_a == comb[0])
        else $error("top output not driven by lookup in bypass");

    a_both_copies_out: assert property (
        s_capture0 ##0 !st_r.cfg.oa0 && st_r.cfg.ob0 ##1 !aclr[0] && !cluster_ctl.aload
        |-> cell_out.top_route_b == $past(cell_out.top_route_a))
        else $error("registered copy does not match earlier unregistered copy");

    a_ext_second_cell_register_off: assert property (mode == ALC_EXTENDED ##1 mode == ALC_EXTENDED
        |-> !st_r.q[1] && !cell_out.bot_route_a [*1])
        else $error("second register active in extended mode");

    a_no_first_ena: assert property (s_capture0 ##0 st_r.cfg.aload_used && !st_r.cfg.esel0
        |=> st_r.q[0] == $past(comb[0]))
        else $error("first enable still gates under async load use");

    a_sload_loads_e: assert property (!aclr[0] && !cluster_ctl.aload && ena[0] && !cluster_ctl.sclr
        && cluster_ctl.sload && !off[0] |=> st_r.q[0] == $past(e_in[0]))
        else $error("sync load did not take load data");

    a_read_cfg_data: assert property (s_read_cfg |=> hrdata == 32'(st_r.cfg))
        else $error("configuration read back wrong");

endmodule : alc_adaptive_logic_cell

//--- core/alc_regs.svh
// Purpose: register offsets, write masks and reset values of the logic cell
// Assumes: one aligned 32-bit word per register
// Notes:   field layout of the configuration word is the package's alc_cfg_s
`ifndef ALC_REGS_SVH
`define ALC_REGS_SVH

`define ALC_CFG_OFS      8'h00
`define ALC_STAT_OFS     8'h04
`define ALC_MASK0_LO_OFS 8'h08
`define ALC_MASK0_HI_OFS 8'h0c
`define ALC_MASK1_LO_OFS 8'h10
`define ALC_MASK1_HI_OFS 8'h14

`define ALC_CFG_RST      32'h0000_0000
`define ALC_CFG_WMASK    32'h0001_ffff
`define ALC_MASK_RST     64'h0000_0000_0000_0000

`define ALC_ST_Q0        0
`define ALC_ST_Q1        1
`define ALC_ST_COMB0     2
`define ALC_ST_COMB1     3
`define ALC_ST_COUT      4
`define ALC_ST_SOUT      5

`define ALC_HSIZE_WORD   3'h2

`endif

//--- core/alc_pkg.sv
// Purpose: types shared by the logic cell and its bench
// Assumes: nothing beyond the register header
// Notes:   struct layouts fix the field positions of the configuration word
package alc_pkg;

    typedef enum logic [1:0] {
        ALC_NORMAL   = 2'b00,
        ALC_EXTENDED = 2'b01,
        ALC_ARITH    = 2'b10,
        ALC_SHARED   = 2'b11
    } alc_mode_e;

    typedef enum logic [1:0] {
        ALC_D_LOOKUP = 2'b00,
        ALC_D_PACK   = 2'b01,
        ALC_D_CHAIN  = 2'b10,
        ALC_D_HOLD   = 2'b11
    } alc_dsel_e;

    typedef struct packed {
        logic [14:0] rsvd;
        logic        ob1;
        logic        oa1;
        logic        ob0;
        logic        oa0;
        logic        csel1;
        logic        csel0;
        logic        esel1;
        logic        esel0;
        alc_dsel_e   dsel1;
        alc_dsel_e   dsel0;
        logic        fb1;
        logic        fb0;
        logic        aload_used;
        alc_mode_e   mode;
    } alc_cfg_s;

    typedef struct packed {
        logic clear_first;
        logic clear_second;
        logic aload;
        logic sclr;
        logic sload;
        logic cluster_clock_enable_first;
        logic cluster_clock_enable_second;
    } alc_ctl_s;

    typedef struct packed {
        logic in_a;
        logic in_b;
        logic in_c;
        logic in_d;
        logic upper_private_input_e;
        logic upper_private_input_f;
        logic lower_private_input_e;
        logic lower_private_input_f;
    } alc_din_s;

    typedef struct packed {
        logic top_route_a;
        logic top_route_b;
        logic top_local;
        logic bot_route_a;
        logic bot_route_b;
        logic bot_local;
    } alc_dout_s;

    typedef struct packed {
        alc_cfg_s    cfg;
        logic [63:0] mask0;
        logic [63:0] mask1;
        logic [1:0]  q;
        logic        pend;
        logic        pwr;
        logic [7:0]  paddr;
        logic [31:0] rdata;
    } alc_state_s;

endpackage : alc_pkg

//--- sim/alc_far_model.sv
// Purpose: neighbouring cells and cluster control that feed one logic cell
// Assumes: requests change right after a rising edge of hclk
// Notes:   chain input is the upstream cell register, one edge behind its request
module alc_far_model
    import alc_pkg::*;
(
    // clock and reset
    input  wire logic     hclk,
    input  wire logic     hresetn,
    // requested levels
    input  wire alc_ctl_s ctl_req,
    input  wire alc_din_s din_req,
    input  wire logic     cin_req,
    input  wire logic     sin_req,
    input  wire logic     chn_req,
    // toward the cell
    output alc_ctl_s      cluster_ctl,
    output alc_din_s      cell_in,
    output logic          carry_in,
    output logic          share_in,
    output logic          chain_in
);
    assign cluster_ctl = ctl_req;
    assign cell_in     = din_req;
    assign carry_in    = cin_req;
    assign share_in    = sin_req;

    // upstream register of the chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_in <= 1'b0;
        end else begin
            chain_in <= chn_req;
        end
    end
endmodule : alc_far_model

//--- sim/tb_top.sv
// Purpose: self-checking bench of the adaptive logic cell
// Assumes: zero-wait ahb-lite slave, hready looped back from hreadyout
// Notes:   inputs change on rising edges, cell outputs are judged at falling edges, bus read data at rising edges
`include "alc_regs.svh"
module tb_top
    import alc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [63:0] M0 = 64'h0123_4567_89ab_cdef;
    localparam logic [63:0] M1 = 64'h9e37_79b9_7f4a_7c15;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    alc_ctl_s    ctl_q, cluster_ctl;
    alc_din_s    din_q, cell_in;
    logic        cin_q, sin_q, chn_q, carry_in, share_in, chain_in;
    alc_dout_s   cell_out;
    logic        carry_out, share_out, chain_out;
    alc_cfg_s    cfg;
    int          errors, checked;

    alc_far_model far (.hclk(hclk), .hresetn(hresetn), .ctl_req(ctl_q), .din_req(din_q),
        .cin_req(cin_q), .sin_req(sin_q), .chn_req(chn_q), .cluster_ctl(cluster_ctl),
        .cell_in(cell_in), .carry_in(carry_in), .share_in(share_in), .chain_in(chain_in));

    alc_adaptive_logic_cell #(.HALVES(2)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cluster_ctl(cluster_ctl), .cell_in(cell_in), .carry_in(carry_in), .share_in(share_in),
        .chain_in(chain_in), .cell_out(cell_out), .carry_out(carry_out),
        .share_out(share_out), .chain_out(chain_out));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic conclude;
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk_w

    task automatic chk_b(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chk_b

    // address phase held until hready, then data phase until hready
    task automatic bus_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                            output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= `ALC_HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk_b("hresp", 1'b0, hresp);
    endtask : bus_xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] junk;
        bus_xfer(a, 1'b1, d, junk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_xfer(a, 1'b0, 32'h0, d);
    endtask : rd

    task automatic set_masks(input logic [63:0] m0, input logic [63:0] m1);
        wr(`ALC_MASK0_LO_OFS, m0[31:0]);
        wr(`ALC_MASK0_HI_OFS, m0[63:32]);
        wr(`ALC_MASK1_LO_OFS, m1[31:0]);
        wr(`ALC_MASK1_HI_OFS, m1[63:32]);
    endtask : set_masks

    // order a b c d, upper e f, lower e f
    function automatic alc_din_s idx_din(input int i);
        return {i[0], i[1], i[2], i[3], i[4], i[5], i[4], i[5]};
    endfunction : idx_din

    task automatic t_regs;
        logic [31:0] d;
        rd(`ALC_CFG_OFS, d);
        chk_w("cfg_rst", `ALC_CFG_RST, d);
        rd(`ALC_MASK1_HI_OFS, d);
        chk_w("mask_rst", 32'h0, d);
        wr(`ALC_CFG_OFS, 32'hffff_ffff);
        rd(`ALC_CFG_OFS, d);
        chk_w("cfg_wmask", `ALC_CFG_WMASK, d);
        wr(8'h20, 32'h1234_5678);
        rd(8'h20, d);
        chk_w("unmapped", 32'h0, d);
    endtask : t_regs

    task automatic t_lut;
        set_masks(M0, M1);
        cfg = '0;
        wr(`ALC_CFG_OFS, cfg);
        for (int i = 0; i < 64; i++) begin
            din_q <= idx_din(i);
            @(negedge hclk);
            chk_b("top_a", M0[i], cell_out.top_route_a);
            chk_b("top_b", M0[i], cell_out.top_route_b);
            chk_b("bot_a", M1[i], cell_out.bot_route_a);
            chk_b("bot_b", M1[i], cell_out.bot_route_b);
            chk_b("top_loc", M0[i], cell_out.top_local);
            chk_b("bot_loc", M1[i], cell_out.bot_local);
            @(posedge hclk);
        end
    endtask : t_lut

    task automatic t_capture;
        cfg = '0;
        cfg.ob0 = 1'b1;
        cfg.ob1 = 1'b1;
        cfg.esel1 = 1'b1;
        wr(`ALC_CFG_OFS, cfg);
        din_q <= idx_din(42);
        ctl_q <= 7'h03;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("q0_reg", M0[42], cell_out.top_route_b);
        chk_b("q0_comb", M0[42], cell_out.top_route_a);
        chk_b("q1_reg", M1[42], cell_out.bot_route_b);
        @(posedge hclk);
        din_q <= idx_din(60);
        ctl_q <= 7'h01;   // second enable only
        @(posedge hclk);
        @(negedge hclk);
        chk_b("q0_hold", M0[42], cell_out.top_route_b);
        chk_b("comb_new", M0[60], cell_out.top_route_a);
        chk_b("q1_new", M1[60], cell_out.bot_route_b);
        @(posedge hclk);
    endtask : t_capture

    task automatic t_async;
        cfg = '0;
        cfg.ob0 = 1'b1;
        cfg.aload_used = 1'b1;
        wr(`ALC_CFG_OFS, cfg);
        din_q <= 8'h48;   // lookup gives 0, upper e is 1
        ctl_q <= 7'h04;   // sload, first enable low
        @(posedge hclk);
        @(negedge hclk);
        chk_b("sload_en", 1'b1, cell_out.top_route_b);
        @(posedge hclk);
        ctl_q <= 7'h0c;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("sclr", 1'b0, cell_out.top_route_b);
        @(posedge hclk);
        ctl_q <= 7'h10;
        @(negedge hclk);
        chk_b("aload_now", 1'b1, cell_out.top_route_b);
        @(posedge hclk);
        ctl_q <= 7'h5c;   // clear beside aload and sync controls
        @(negedge hclk);
        chk_b("aclr_wins", 1'b0, cell_out.top_route_b);
        @(posedge hclk);
        ctl_q <= 7'h00;
        @(posedge hclk);
    endtask : t_async

    task automatic t_feedback;
        set_masks(64'hffff_ffff_0000_0000, M1);
        cfg = '0;
        cfg.fb0 = 1'b1;
        cfg.ob0 = 1'b1;
        wr(`ALC_CFG_OFS, cfg);
        din_q <= 8'h08;
        ctl_q <= 7'h06;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("fb_set", 1'b1, cell_out.top_route_a);
        @(posedge hclk);
        ctl_q <= 7'h02;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("fb_keep", 1'b1, cell_out.top_route_b);
        @(posedge hclk);
        ctl_q <= 7'h0a;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("fb_clr", 1'b0, cell_out.top_route_a);
        @(posedge hclk);
    endtask : t_feedback

    task automatic t_ext;
        set_masks(M0, M1);
        cfg = '0;
        cfg.mode = ALC_EXTENDED;
        cfg.ob1 = 1'b1;
        wr(`ALC_CFG_OFS, cfg);
        for (int i = 0; i < 128; i++) begin
            din_q <= {i[0], i[1], i[2], i[3], i[4], i[6], i[5], 1'b0};
            @(negedge hclk);
            chk_b("ext_mux", i[6] ? M1[{i[5], i[3:0]}] : M0[{i[4], i[3:0]}],
                  cell_out.top_route_a);
            @(posedge hclk);
        end
        din_q <= 8'h02;
        ctl_q <= 7'h07;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("ext_q1_off", 1'b0, cell_out.bot_route_b);
        chk_b("ext_chain", 1'b0, chain_out);
        @(posedge hclk);
    endtask : t_ext

    // arithmetic then shared arithmetic, pack and chain data selects
    task automatic t_arith;
        cfg = '0;
        cfg.mode = ALC_ARITH;
        cfg.dsel0 = ALC_D_PACK;
        cfg.dsel1 = ALC_D_CHAIN;
        cfg.ob0 = 1'b1;
        cfg.ob1 = 1'b1;
        wr(`ALC_CFG_OFS, cfg);
        din_q <= 8'h04;   // upper f only
        cin_q <= 1'b1;
        ctl_q <= 7'h03;
        @(posedge hclk);
        @(negedge hclk);
        chk_b("ar_sum0", 1'b1, cell_out.top_route_a);
        chk_b("ar_sum1", 1'b0, cell_out.bot_route_a);
        chk_b("ar_cout", 1'b1, carry_out);
        chk_b("ar_sout", 1'b0, share_out);
        chk_b("ar_pack", 1'b1, cell_out.top_route_b);
        @(posedge hclk);
        @(negedge hclk);
        chk_b("ar_chain", 1'b1, cell_out.bot_route_b);
        chk_b("chain_out", 1'b1, chain_out);
        @(posedge hclk);
        cfg.mode = ALC_SHARED;
        wr(`ALC_CFG_OFS, cfg);
        @(negedge hclk);
        chk_b("sh_sum0", 1'b0, cell_out.top_route_a);
        chk_b("sh_sum1", 1'b1, cell_out.bot_route_a);
        chk_b("sh_cout", 1'b1, carry_out);
        @(posedge hclk);
        cin_q <= 1'b0;
        ctl_q <= 7'h00;
        @(posedge hclk);
    endtask : t_arith

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        ctl_q = '0;
        din_q = '0;
        cin_q = 1'b0;
        sin_q = 1'b0;
        chn_q = 1'b0;
        errors = 0;
        checked = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_lut;
        t_capture;
        t_async;
        t_feedback;
        t_ext;
        t_arith;
        conclude;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        conclude;
    end
endmodule : tb_top
